// [hw/mulsub_pkg.sv]
package mulsub_pkg;

  // ************************************************************
  // register map, byte addresses on the AXI4-Lite slave
  // ************************************************************
  localparam logic [7:0]  CTRL_OFF     = 8'h00;
  localparam logic [7:0]  FACTOR_A_OFF = 8'h04;
  localparam logic [7:0]  FACTOR_B_OFF = 8'h08;
  localparam logic [7:0]  MIN_LO_OFF   = 8'h0C;
  localparam logic [7:0]  MIN_HI_OFF   = 8'h10;
  localparam logic [7:0]  RES_LO_OFF   = 8'h14;
  localparam logic [7:0]  RES_HI_OFF   = 8'h18;
  localparam logic [7:0]  STATUS_OFF   = 8'h1C;

  // control word fields
  localparam int          CTRL_OP_LSB    = 0;
  localparam int          CTRL_N_BIT     = 4;
  localparam int          CTRL_IMM_BIT   = 5;
  localparam int          CTRL_K_LSB     = 6;
  localparam int          CTRL_START_BIT = 31;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

  // status word fields
  localparam int          ST_V    = 0;
  localparam int          ST_AV   = 1;
  localparam int          ST_SV   = 2;
  localparam int          ST_SAV  = 3;
  localparam int          ST_DONE = 4;

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ************************************************************
  // arithmetic limits
  // ************************************************************
  localparam logic [31:0] S32_MAX  = 32'h7FFF_FFFF;
  localparam logic [31:0] S32_MIN  = 32'h8000_0000;
  localparam logic [31:0] U32_MAX  = 32'hFFFF_FFFF;
  localparam logic [63:0] S64_MAX  = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] S64_MIN  = 64'h8000_0000_0000_0000;
  localparam logic [15:0] HALF_MIN = 16'h8000;
  localparam logic [31:0] RND_HALF = 32'h0000_8000;

  typedef enum logic [3:0] {
    OP_MW_PACKED      = 4'h0,
    OP_MW_FRAC        = 4'h1,
    OP_MW_SAT_S       = 4'h2,
    OP_MW_SAT_U       = 4'h3,
    OP_MW_S           = 4'h4,
    OP_MW_U           = 4'h5,
    OP_W_SAT_S        = 4'h6,
    OP_W_SAT_U        = 4'h7,
    OP_RND_PACKED     = 4'h8,
    OP_RND_FRAC       = 4'h9,
    OP_RND_SAT_PACKED = 4'hA,
    OP_RND_SAT_FRAC   = 4'hB
  } op_t;

  typedef struct packed {
    logic [31:0] word;
    logic        v;
    logic        av;
  } lane_out_t;

  typedef struct packed {
    logic [63:0] res;
    logic        v;
    logic        av;
  } calc_t;

endpackage

// [hw/frac_lane.sv]
`timescale 1ns/1ps
module frac_lane
(
  input  wire logic [15:0]           fac_a,
  input  wire logic [15:0]           fac_b,
  input  wire logic [31:0]           acc,
  input  wire logic                  n,
  input  wire logic                  rnd,
  input  wire logic                  sat,
  output mulsub_pkg::lane_out_t      out
);
  import mulsub_pkg::*;

  logic [31:0] prod;
  logic [31:0] prod_j;
  logic [33:0] diff;
  logic        ovf;
  logic [31:0] val;

  always_comb
  begin
    prod   = 32'($signed(fac_a) * $signed(fac_b));
    // RULE7: shift when justified
    prod_j = n ? {prod[30:0], 1'b0} : prod;
    // RULE8: largest fraction substituted
    if (n && fac_a == HALF_MIN && fac_b == HALF_MIN)
      prod_j = S32_MAX;
    diff = {{2{acc[31]}}, acc} - {{2{prod_j[31]}}, prod_j};
    // RULE9: rounding of the difference
    if (rnd)
      diff = diff + {2'b00, RND_HALF};
    // RULE13: overflow on the final value
    ovf = !(&diff[33:31] || !(|diff[33:31]));
    // RULE12: each lane clamps alone
    if (sat && ovf)
      val = diff[33] ? S32_MIN : S32_MAX;
    else
      val = diff[31:0];
    // RULE10: low half forced to zero
    out.word = rnd ? {val[31:16], 16'h0000} : val;
    out.v    = ovf;
    // RULE15: near-overflow from top bits
    out.av   = val[31] ^ val[30];
  end

endmodule

// [hw/multiply_subtract_datapath.sv]
// Function
// RULE1: packed multiword: sum products, shift 16, subtract
// RULE2: fractional multiword: upper product, shift 16, subtract
// RULE3: 64-bit minus full 32x32 product, signed/unsigned
// RULE4: saturating forms clamp on overflow
// RULE5: nine-bit immediate sign- or zero-extended
// RULE6: 32-bit saturating multiply-subtract, signed/unsigned
// RULE7: justification shifts halfword product by one; OP_MW_PACKED and OP_MW_FRAC ignore it
// RULE8: justified 0x8000 squared gives largest fraction
// RULE9: packed rounding upper lane from upper word
// RULE10: single-lane rounding zeroes low halfword
// RULE11: packed lanes flag overflow independently
// RULE12: packed saturating lanes clamp independently
// RULE13: flags taken from final difference, with sticky
// RULE14: sticky flags set, never cleared by operations
// RULE15: advanced overflow when top two bits differ
`timescale 1ns/1ps
module multiply_subtract_datapath
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import mulsub_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [31:0] ctrl_reg, ctrl_next, fa_reg, fa_next, fb_reg, fb_next;
  logic [31:0] ml_reg, ml_next, mh_reg, mh_next, rl_reg, rl_next, rh_reg, rh_next;
  logic        v_reg, v_next, av_reg, av_next, sv_reg, sv_next, sav_reg, sav_next;
  logic        done_reg, done_next, go_reg, go_next;
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0]  bresp_next, rresp_next;
  logic [31:0] rdata_next;
  logic        do_write, sv_clr, sav_clr, done_clr;

  // ************************************************************
  // datapath
  // ************************************************************
  op_t         op;
  logic        sgn, use_imm, just;
  logic [31:0] b_op;
  logic [63:0] prod_s, prod_u, sub, e_src;
  logic [31:0] ph_hi, ph_lo;
  logic [32:0] sum33;
  logic [64:0] diff65;
  logic [65:0] diff66;
  logic        v64, v32;
  calc_t       calc;
  lane_out_t   lane_hi, lane_lo;
  logic        rnd_op, sat_lane, packed_rnd;

  assign op         = op_t'(ctrl_reg[CTRL_OP_LSB +: 4]);
  assign just       = ctrl_reg[CTRL_N_BIT];
  assign use_imm    = ctrl_reg[CTRL_IMM_BIT];
  assign rnd_op     = op inside {OP_RND_PACKED, OP_RND_FRAC, OP_RND_SAT_PACKED, OP_RND_SAT_FRAC};
  assign sat_lane   = op inside {OP_RND_SAT_PACKED, OP_RND_SAT_FRAC};
  assign packed_rnd = op inside {OP_RND_PACKED, OP_RND_SAT_PACKED};
  assign sgn        = !(op inside {OP_MW_SAT_U, OP_MW_U, OP_W_SAT_U});
  assign e_src      = {mh_reg, ml_reg};

  // RULE9: upper lane subtracts from the upper word in packed forms, from the lower word otherwise
  frac_lane u_lane_hi
  (
    .fac_a (fa_reg[31:16]),
    .fac_b (fb_reg[31:16]),
    .acc   (packed_rnd ? mh_reg : ml_reg),
    .n     (just),
    .rnd   (1'b1),
    .sat   (sat_lane),
    .out   (lane_hi)
  );

  frac_lane u_lane_lo
  (
    .fac_a (fa_reg[15:0]),
    .fac_b (fb_reg[15:0]),
    .acc   (ml_reg),
    .n     (just),
    .rnd   (1'b1),
    .sat   (sat_lane),
    .out   (lane_lo)
  );

  always_comb
  begin
    // RULE5: immediate widened before multiply
    if (use_imm)
      b_op = sgn ? {{23{ctrl_reg[CTRL_K_LSB + 8]}}, ctrl_reg[CTRL_K_LSB +: 9]}
                 : {23'h000000, ctrl_reg[CTRL_K_LSB +: 9]};
    else
      b_op = fb_reg;
    prod_s = 64'($signed({{32{fa_reg[31]}}, fa_reg}) * $signed({{32{b_op[31]}}, b_op}));
    prod_u = 64'({32'h0000_0000, fa_reg} * {32'h0000_0000, b_op});
    ph_hi  = 32'($signed(fa_reg[31:16]) * $signed(fb_reg[31:16]));
    ph_lo  = 32'($signed(fa_reg[15:0]) * $signed(fb_reg[15:0]));
    sum33  = {ph_hi[31], ph_hi} + {ph_lo[31], ph_lo};
    case (op)
      // RULE1: sum of products, extended and shifted
      OP_MW_PACKED: sub = {{15{sum33[32]}}, sum33, 16'h0000};
      // RULE2: upper product, extended and shifted
      OP_MW_FRAC:   sub = {{16{ph_hi[31]}}, ph_hi, 16'h0000};
      default:      sub = sgn ? prod_s : prod_u;
    endcase
    // RULE3: 64-bit minus full product
    diff65 = sgn ? {e_src[63], e_src} - {sub[63], sub} : {1'b0, e_src} - {1'b0, sub};
    v64    = sgn ? diff65[64] ^ diff65[63] : diff65[64];
    // RULE6: exact 32-bit difference kept wide
    diff66 = sgn ? {{34{ml_reg[31]}}, ml_reg} - {{2{prod_s[63]}}, prod_s}
                 : {34'h0, ml_reg} - {2'b00, prod_u};
    v32    = sgn ? !(&diff66[65:31] || !(|diff66[65:31])) : diff66[65];
    calc   = '0;
    case (op)
      OP_MW_PACKED, OP_MW_FRAC, OP_MW_S, OP_MW_U:
      begin
        calc.res = diff65[63:0];
        calc.v   = v64;
      end
      OP_MW_SAT_S, OP_MW_SAT_U:
      begin
        // RULE4: clamp to the 64-bit range
        if (v64)
          calc.res = sgn ? (diff65[64] ? S64_MIN : S64_MAX) : 64'h0;
        else
          calc.res = diff65[63:0];
        calc.v = v64;
      end
      OP_W_SAT_S, OP_W_SAT_U:
      begin
        // RULE4: clamp to the 32-bit range
        if (v32)
          calc.res[31:0] = sgn ? (diff66[65] ? S32_MIN : S32_MAX)
                               : (diff66[65] ? 32'h0000_0000 : U32_MAX);
        else
          calc.res[31:0] = diff66[31:0];
        calc.v = v32;
      end
      OP_RND_PACKED, OP_RND_SAT_PACKED:
      begin
        calc.res[31:0] = {lane_hi.word[31:16], lane_lo.word[31:16]};
        // RULE11: lane flags merged after each is found
        calc.v  = lane_hi.v | lane_lo.v;
        calc.av = lane_hi.av | lane_lo.av;
      end
      OP_RND_FRAC, OP_RND_SAT_FRAC:
      begin
        // RULE10: single lane, low half zero
        calc.res[31:0] = lane_hi.word;
        calc.v         = lane_hi.v;
        calc.av        = lane_hi.av;
      end
      default:
        calc = '0;
    endcase
    // RULE15: top two bits of the final value
    if (op inside {OP_W_SAT_S, OP_W_SAT_U})
      calc.av = calc.res[31] ^ calc.res[30];
    else if (!rnd_op)
      calc.av = calc.res[63] ^ calc.res[62];
  end

  // ************************************************************
  // register bus
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  always_comb
  begin
    aw_full_next = aw_full_reg | (awvalid & awready);
    w_full_next  = w_full_reg | (wvalid & wready);
    awaddr_next  = (awvalid & awready) ? awaddr : awaddr_reg;
    {wdata_next, wstrb_next} = (wvalid & wready) ? {wdata, wstrb} : {wdata_reg, wstrb_reg};
    {bvalid_next, bresp_next} = {bvalid & ~bready, bresp};
    do_write     = aw_full_reg & w_full_reg & ~bvalid;
    {ctrl_next, fa_next, fb_next, ml_next, mh_next} = {ctrl_reg, fa_reg, fb_reg, ml_reg, mh_reg};
    {go_next, sv_clr, sav_clr, done_clr} = 4'h0;
    if (do_write)
    begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case ({awaddr_reg[7:2], 2'b00})
        CTRL_OFF:
        begin
          ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg) & ~(32'h1 << CTRL_START_BIT);
          go_next   = wstrb_reg[3] & wdata_reg[CTRL_START_BIT];
        end
        FACTOR_A_OFF: fa_next = merge(fa_reg, wdata_reg, wstrb_reg);
        FACTOR_B_OFF: fb_next = merge(fb_reg, wdata_reg, wstrb_reg);
        MIN_LO_OFF:   ml_next = merge(ml_reg, wdata_reg, wstrb_reg);
        MIN_HI_OFF:   mh_next = merge(mh_reg, wdata_reg, wstrb_reg);
        RES_LO_OFF, RES_HI_OFF: ;
        STATUS_OFF:
        begin
          sv_clr   = wstrb_reg[0] & wdata_reg[ST_SV];
          sav_clr  = wstrb_reg[0] & wdata_reg[ST_SAV];
          done_clr = wstrb_reg[0] & wdata_reg[ST_DONE];
        end
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    awready_next = ~aw_full_next;
    wready_next  = ~w_full_next;
    rvalid_next  = rvalid & ~rready;
    arready_next = ~rvalid_next;
    {rdata_next, rresp_next} = {rdata, rresp};
    if (arvalid & arready)
    begin
      rvalid_next  = 1'b1;
      arready_next = 1'b0;
      rresp_next   = RESP_OKAY;
      case ({araddr[7:2], 2'b00})
        CTRL_OFF:     rdata_next = ctrl_reg;
        FACTOR_A_OFF: rdata_next = fa_reg;
        FACTOR_B_OFF: rdata_next = fb_reg;
        MIN_LO_OFF:   rdata_next = ml_reg;
        MIN_HI_OFF:   rdata_next = mh_reg;
        RES_LO_OFF:   rdata_next = rl_reg;
        RES_HI_OFF:   rdata_next = rh_reg;
        STATUS_OFF:   rdata_next = {27'h0, done_reg, sav_reg, sv_reg, av_reg, v_reg};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    {rh_next, rl_next, v_next, av_next} = go_reg ? {calc.res, calc.v, calc.av}
                                                 : {rh_reg, rl_reg, v_reg, av_reg};
    // RULE14: a new set beats a software clear
    sv_next   = (sv_reg & ~sv_clr) | (go_reg & calc.v);
    sav_next  = (sav_reg & ~sav_clr) | (go_reg & calc.av);
    done_next = (done_reg & ~done_clr) | go_reg;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RST;
      {fa_reg, fb_reg, ml_reg, mh_reg, rl_reg, rh_reg} <= {6{32'h0000_0000}};
      {v_reg, av_reg, sv_reg, sav_reg, done_reg, go_reg} <= 6'h00;
      {aw_full_reg, w_full_reg, awaddr_reg, wdata_reg, wstrb_reg} <= 46'h0;
      {awready, wready, arready, bvalid, rvalid} <= 5'h1C;
      {bresp, rresp, rdata} <= {RESP_OKAY, RESP_OKAY, 32'h0000_0000};
    end
    else
    begin
      {ctrl_reg, fa_reg, fb_reg, ml_reg, mh_reg, rl_reg, rh_reg} <=
        {ctrl_next, fa_next, fb_next, ml_next, mh_next, rl_next, rh_next};
      {v_reg, av_reg, sv_reg, sav_reg, done_reg, go_reg} <=
        {v_next, av_next, sv_next, sav_next, done_next, go_next};
      {aw_full_reg, w_full_reg, awaddr_reg, wdata_reg, wstrb_reg} <=
        {aw_full_next, w_full_next, awaddr_next, wdata_next, wstrb_next};
      {awready, wready, arready, bvalid, rvalid} <=
        {awready_next, wready_next, arready_next, bvalid_next, rvalid_next};
      {bresp, rresp, rdata} <= {bresp_next, rresp_next, rdata_next};
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // independent reference values used only by the checks
  logic [63:0] chk_frac, chk_pack, chk_mws;
  logic [31:0] chk_corner, chk_rndhi;
  assign chk_frac   = e_src - {{16{ph_hi[31]}}, ph_hi, 16'h0000};
  assign chk_pack   = e_src - 64'($signed(sum33) <<< 16);
  assign chk_mws    = 64'($signed(e_src) - $signed(fa_reg) * $signed(fb_reg));
  assign chk_corner = (ml_reg - S32_MAX + RND_HALF) & 32'hFFFF_0000;
  assign chk_rndhi  = (mh_reg - ph_hi + RND_HALF) & 32'hFFFF_0000;

  a_packed_mw_result: assert property (go_reg && op == OP_MW_PACKED |=> // RULE1
    {rh_reg, rl_reg} == $past(chk_pack)) else $error("packed multiword result wrong");
  a_frac_mw_result: assert property (go_reg && op == OP_MW_FRAC |=> // RULE2
    {rh_reg, rl_reg} == $past(chk_frac)) else $error("fractional multiword result wrong");
  a_mw_signed_value: assert property (go_reg && op == OP_MW_SAT_S && !use_imm && !calc.v // RULE3
    |=> {rh_reg, rl_reg} == $past(chk_mws)) else $error("signed multiword result wrong");
  a_word_sat_clamp: assert property (go_reg && op == OP_W_SAT_S && calc.v |=> // RULE4
    v_reg && (rl_reg == S32_MAX || rl_reg == S32_MIN)) else $error("signed word not clamped");
  a_unsigned_floor: assert property (go_reg && op == OP_MW_SAT_U && calc.v |=> // RULE4
    {rh_reg, rl_reg} == 64'h0) else $error("unsigned multiword not floored");
  a_imm_sign_ext: assert property (use_imm && sgn |-> // RULE5
    b_op[31:8] == {24{ctrl_reg[CTRL_K_LSB + 8]}}) else $error("immediate not sign-extended");
  a_corner_fraction: assert property (go_reg && op == OP_RND_FRAC && just && // RULE8
    fa_reg[31:16] == HALF_MIN && fb_reg[31:16] == HALF_MIN |=>
    rl_reg == $past(chk_corner)) else $error("corner fraction not used");
  a_rnd_upper_lane: assert property (go_reg && op == OP_RND_PACKED && !just |=> // RULE9
    (rl_reg & 32'hFFFF_0000) == $past(chk_rndhi)) else $error("upper lane rounding wrong");
  a_rnd_low_zero: assert property (go_reg && (op == OP_RND_FRAC || op == OP_RND_SAT_FRAC) // RULE10
    |=> rl_reg[15:0] == 16'h0000 && rh_reg == 32'h0) else $error("low halfword not zero");
  a_sticky_follow: assert property (go_reg && calc.v |=> v_reg && sv_reg) // RULE13
    else $error("sticky overflow not set");
  a_sticky_hold: assert property (sv_reg && !sv_clr |=> sv_reg) // RULE14
    else $error("sticky overflow dropped");
  a_av_top_bits: assert property (go_reg && op == OP_MW_S |=> // RULE15
    av_reg == (rh_reg[31] ^ rh_reg[30])) else $error("advanced overflow wrong");

  c_packed_mw:  cover property (go_reg && op == OP_MW_PACKED);
  c_word_clamp: cover property (go_reg && op == OP_W_SAT_S && calc.v);
  c_lane_split: cover property (go_reg && op == OP_RND_SAT_PACKED && lane_lo.v && !lane_hi.v);
  c_corner:     cover property (go_reg && just && fa_reg[31:16] == HALF_MIN &&
                                fb_reg[31:16] == HALF_MIN);

endmodule

// [test/multiply_subtract_datapath_test.sv]
`timescale 1ns/1ps
module multiply_subtract_datapath_test;
  import mulsub_pkg::*;

  logic        clock;
  logic        rst_n;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  int          error_cnt;
  int          total_checks;
  logic [31:0] rd_val;
  logic [31:0] last_st;

  multiply_subtract_datapath dut (
    .clock(clock), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  always #2.5 clock = ~clock;

  // ************************************************************
  // compare and closing
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: response %b expected %b", $time, got, exp);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("MISMATCH at %0t: bus handshake timed out", $time);
    test_done();
  endtask

  // ************************************************************
  // bus master: each channel released only when taken
  // ************************************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_d;
    logic w_d;
    logic b_d;
    aw_d = 1'b0;
    w_d  = 1'b0;
    b_d  = 1'b0;
    n    = 0;
    @(posedge clock);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_d && n < 200)
    begin
      @(posedge clock);
      n++;
      if (!aw_d && awready)
      begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready)
      begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw_d && w_d && bvalid)
      begin
        b_d = 1'b1;
        bready <= 1'b0;
        chk_resp(bresp, er);
      end
    end
    if (!b_d)
      hang();
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int   n;
    logic ar_d;
    logic r_d;
    ar_d = 1'b0;
    r_d  = 1'b0;
    n    = 0;
    d    = 32'h0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r_d && n < 200)
    begin
      @(posedge clock);
      n++;
      if (!ar_d && arready)
      begin
        ar_d = 1'b1;
        arvalid <= 1'b0;
      end
      if (ar_d && rvalid)
      begin
        r_d = 1'b1;
        rready <= 1'b0;
        d = rdata;
        chk_resp(rresp, er);
      end
    end
    if (!r_d)
      hang();
  endtask

  // ************************************************************
  // one operation: load operands, start, compare results
  // ************************************************************
  function automatic logic [31:0] ctl(input logic [3:0] op, input int n, input int ie,
                                      input logic [8:0] imm);
    ctl = {1'b1, 16'h0, imm, ie[0], n[0], op};
  endfunction

  task automatic do_op(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b,
                       input logic [63:0] m, input logic [63:0] e, input logic [1:0] ef,
                       input logic [1:0] fm);
    logic [31:0] rh;
    logic [31:0] rl;
    axi_wr(FACTOR_A_OFF, a, RESP_OKAY);
    axi_wr(FACTOR_B_OFF, b, RESP_OKAY);
    axi_wr(MIN_LO_OFF, m[31:0], RESP_OKAY);
    axi_wr(MIN_HI_OFF, m[63:32], RESP_OKAY);
    // clear done first so a stale flag from the last operation cannot pass
    axi_wr(STATUS_OFF, 32'h0000_0010, RESP_OKAY);
    axi_wr(CTRL_OFF, c, RESP_OKAY);
    // results land one edge after the start write commits; three leaves slack
    repeat (3) @(posedge clock);
    axi_rd(RES_HI_OFF, RESP_OKAY, rh);
    axi_rd(RES_LO_OFF, RESP_OKAY, rl);
    axi_rd(STATUS_OFF, RESP_OKAY, last_st);
    chk32(rh, e[63:32]);
    chk32(rl, e[31:0]);
    chk32({30'h0, last_st[1:0] & fm}, {30'h0, ef & fm});
    chk32({31'h0, last_st[ST_DONE]}, 32'h1);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    clock        = 1'b0;
    rst_n        = 1'b0;
    awaddr       = 8'h0;
    awvalid      = 1'b0;
    wdata        = 32'h0;
    wstrb        = 4'h0;
    wvalid       = 1'b0;
    bready       = 1'b0;
    araddr       = 8'h0;
    arvalid      = 1'b0;
    rready       = 1'b0;
    error_cnt    = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    axi_rd(CTRL_OFF, RESP_OKAY, rd_val);
    chk32(rd_val, CTRL_RST);
    axi_rd(STATUS_OFF, RESP_OKAY, rd_val);
    chk32(rd_val, 32'h0);
    // unmapped place answers with an error and zero data
    axi_wr(8'h20, 32'hA5A5A5A5, RESP_SLVERR);
    axi_rd(8'h20, RESP_SLVERR, rd_val);
    chk32(rd_val, 32'h0);
    do_op(ctl(4'h0, 0, 0, 9'h0), 32'h00020003, 32'h00040005, 64'h0, 64'hFFFFFFFFFFE90000,
          2'h0, 2'h3);
    do_op(ctl(4'h1, 0, 0, 9'h0), 32'hFFFF1234, 32'h00035678, 64'h0, 64'h30000,
          2'h0, 2'h3);
    axi_wr(STATUS_OFF, 32'h0000001C, RESP_OKAY);
    do_op(ctl(4'h2, 0, 0, 9'h0), 32'h1, 32'h1, S64_MIN, S64_MIN, 2'h3, 2'h3);
    chk32(last_st, 32'h0000001F);
    do_op(ctl(4'h3, 0, 0, 9'h0), 32'h2, 32'h3, 64'h5, 64'h0, 2'h1, 2'h3);
    chk32(last_st & 32'h0000000C, 32'h0000000C);
    do_op(ctl(4'h2, 0, 1, 9'h1FF), 32'h5, 32'h0, 64'h0, 64'h5, 2'h0, 2'h3);
    do_op(ctl(4'h3, 0, 1, 9'h1FF), 32'h1, 32'h0, 64'h3E8, 64'h1E9, 2'h0, 2'h3);
    do_op(ctl(4'h6, 0, 0, 9'h0), 32'hFFFFFFFF, 32'h1, 64'h7FFFFFFF, 64'h7FFFFFFF,
          2'h3, 2'h3);
    do_op(ctl(4'h7, 0, 0, 9'h0), 32'h1, 32'h2, 64'h3, 64'h1, 2'h0, 2'h3);
    do_op(ctl(4'h4, 0, 0, 9'h0), 32'h0, 32'h0, 64'h4000000000000000, 64'h4000000000000000,
          2'h2, 2'h3);
    do_op(ctl(4'h5, 0, 0, 9'h0), 32'hFFFFFFFF, 32'h2, 64'h0, 64'hFFFFFFFE00000002,
          2'h0, 2'h0);
    do_op(ctl(4'h9, 0, 0, 9'h0), 32'h40000000, 32'h20000, 64'h0, 64'h0, 2'h0, 2'h3);
    do_op(ctl(4'h9, 1, 0, 9'h0), 32'h40000000, 32'h20000, 64'h0, 64'hFFFF0000,
          2'h0, 2'h3);
    do_op(ctl(4'h9, 1, 0, 9'h0), 32'h80000000, 32'h80000000, 64'h0, 64'h80000000,
          2'h2, 2'h3);
    do_op(ctl(4'hB, 0, 0, 9'h0), 32'h01000000, 32'h01000000, 64'h80000000, 64'h80000000,
          2'h3, 2'h3);
    do_op(ctl(4'hA, 0, 0, 9'h0), 32'hFFFF0001, 32'h00010001, 64'h7FFFFFFF00010000,
          64'h7FFF0001, 2'h3, 2'h3);
    do_op(ctl(4'h8, 0, 0, 9'h0), 32'hFFFF0001, 32'h00010001, 64'h7FFFFFFF00010000,
          64'h80000001, 2'h3, 2'h3);
    do_op(ctl(4'h2, 0, 0, 9'h0), 32'hFFFFFFFF, 32'h3, 64'h10, 64'h13, 2'h0, 2'h3);
    do_op(ctl(4'hA, 0, 0, 9'h0), 32'h0001FFFF, 32'h00010001, 64'h000100007FFFFFFF,
          64'h00017FFF, 2'h3, 2'h3);
    // undefined operation codes give zero and no overflow flags
    do_op(ctl(4'hC, 0, 0, 9'h0), 32'h1, 32'h1, 64'h5, 64'h0, 2'h0, 2'h3);
    test_done();
  end
endmodule
